// ---- logic/icc_clock_ctrl.sv ----
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module icc_clock_ctrl (
    input  wire logic       sys_clk_in,          // 10 mhz system clock
    input  wire logic       rst_in,              // synchronous, active high
    input  wire logic [7:0] addr_in,             // register byte address
    input  wire logic [7:0] wdata_in,            // write data
    input  wire logic       wr_in,               // write strobe
    input  wire logic       rd_in,               // read strobe
    output logic      [7:0] rdata_out,           // read data, cycle after rd_in
    input  wire logic [3:0] osc_mode_config_in,  // configuration mode field
    input  wire logic       pwrup_timer_en_in,   // power-up timer enabled
    input  wire logic       fail_safe_en_in,     // fail-safe monitor enabled
    input  wire logic       watchdog_en_in,      // watchdog enabled
    input  wire logic       two_speed_en_in,     // two-speed start-up enabled
    input  wire logic       dev_clk_tick_in,     // one pulse per device clock
    output logic            fast_src_en_out,     // fast internal source running
    output logic            slow_src_en_out,     // slow internal source running
    output logic      [4:0] fast_trim_out,       // trim to fast source
    output logic      [2:0] post_sel_out,        // postscaler / direct selection
    output logic            lf_from_fast_out,    // 31k leg from fast/256
    output logic            pll_sel_out,         // pll in the clock path
    output logic            crystal_pll_out,     // pll fed from crystal
    output logic            clk_gate_out,        // device clock gate, 1 = pass
    input  wire logic       osc_out_pin_in,      // out pin level
    output logic            osc_out_pin_out,     // out pin drive value
    output logic            osc_out_pin_oe_n_out,// low = driving
    input  wire logic       osc_in_pin_in,       // in pin level
    output logic            osc_in_pin_out,      // in pin drive value
    output logic            osc_in_pin_oe_n_out  // low = driving
);
    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic       lfsrc_reg;                       // low_freq_source_select
    logic       pll_enable_bit_reg;                       // pll_enable_bit
    logic [4:0] tune_reg;                        // tune_value
    logic [2:0] ifs_reg;                         // int_freq_select
    logic [1:0] scs_reg;                         // clock source select
    logic [7:6] port_reg;                        // port latch bits 7:6
    logic [7:6] dir_reg;                         // direction, 1 = input
    logic [7:0] rdata_reg;                       // read data holder
    logic [7:0] rdata_next;                      // read mux
    // mode decode
    logic       int_mode;                        // internal block is primary
    logic       pll_capable;                     // internal pll may run
    logic       pll_want;                        // pll requested in path
    logic       clkout_on;                       // out pin carries clock/4
    logic       ra6_io;                          // out pin is port bit six
    logic       ra7_io;                          // in pin is port bit seven
    // clock-out divider and switch machine
    logic       div_reg;                         // device tick halver
    logic       clkout_reg;                      // divided clock
    icc_pkg::icc_sw_state_t sw_state_reg;        // switching state
    logic [2:0] sw_cnt_reg;                      // ticks spent in state
    logic       pll_sel_reg;                     // pll mux select
    logic       gate_reg;                        // device clock gate
    logic       fast_en_reg;
    logic       slow_en_reg;
    logic       lf_fast_reg;
    logic       xpll_reg;
    logic       out_pin_reg;
    logic       out_oe_n_reg;
    logic       in_pin_reg;
    logic       in_oe_n_reg;

    // decoded register hit, used on both read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    always_comb begin
        int_mode    = (osc_mode_config_in == icc_pkg::MODE_INT_CLKOUT) ||
                      (osc_mode_config_in == icc_pkg::MODE_INT_DUAL_IO);
        pll_capable = int_mode;
        // crystal pll ignores the software bit entirely
        if (osc_mode_config_in == icc_pkg::MODE_CRYSTAL_PLL) begin
            pll_want = 1'b1;
        end else begin
            pll_want = int_mode && pll_enable_bit_reg &&
                       ((ifs_reg == icc_pkg::IFS_8MHZ) || (ifs_reg == icc_pkg::IFS_4MHZ));
        end
        clkout_on = (osc_mode_config_in == icc_pkg::MODE_RES_CAP) ||
                    (osc_mode_config_in == icc_pkg::MODE_INT_CLKOUT);
        ra6_io    = (osc_mode_config_in == icc_pkg::MODE_RES_CAP_IO) ||
                    (osc_mode_config_in == icc_pkg::MODE_INT_DUAL_IO);
        ra7_io    = int_mode;
    end

    // ------------------------------------------------------------
    // tuning register
    // ------------------------------------------------------------
    // the trim goes out at once; the oscillator drifts to it by itself
    // and nothing reports completion, so no settle flag is kept
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            lfsrc_reg <= 1'b0;
            tune_reg  <= icc_pkg::TUNE_RESET;
        end else if (wr_in && hit(addr_in, icc_pkg::TUNING_OFFSET)) begin
            lfsrc_reg <= wdata_in[icc_pkg::LFSRC_BIT];
            tune_reg  <= wdata_in[icc_pkg::TUNE_MSB:0];
        end
    end

    // pll enable is cleared whenever the mode cannot use it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pll_enable_bit_reg <= 1'b0;
        end else if (!pll_capable) begin
            pll_enable_bit_reg <= 1'b0;
        end else if (wr_in && hit(addr_in, icc_pkg::TUNING_OFFSET)) begin
            pll_enable_bit_reg <= wdata_in[icc_pkg::PLL_ENABLE_BIT_BIT];
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ifs_reg <= icc_pkg::IFS_RESET;
            scs_reg <= 2'h0;
        end else if (wr_in && hit(addr_in, icc_pkg::CONTROL_OFFSET)) begin
            ifs_reg <= wdata_in[icc_pkg::IFS_LSB +: 3];
            scs_reg <= wdata_in[icc_pkg::SCS_MSB:0];
        end
    end

    // ------------------------------------------------------------
    // port a latch and direction for the two oscillator pins
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            port_reg <= 2'h0;
            dir_reg  <= 2'h3;                    // inputs after reset, pins float safe
        end else if (wr_in && hit(addr_in, icc_pkg::PORT_OFFSET)) begin
            port_reg <= wdata_in[7:6];
        end else if (wr_in && hit(addr_in, icc_pkg::DIR_OFFSET)) begin
            dir_reg  <= wdata_in[7:6];
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (hit(addr_in, icc_pkg::TUNING_OFFSET)) begin
            // bit five has no storage and stays zero
            rdata_next = {lfsrc_reg, pll_enable_bit_reg & pll_capable, 1'b0, tune_reg};
        end else if (hit(addr_in, icc_pkg::CONTROL_OFFSET)) begin
            rdata_next = {1'b0, ifs_reg, 1'b0, int_mode, scs_reg};
        end else if (hit(addr_in, icc_pkg::PORT_OFFSET)) begin
            // a pin that belongs to the oscillator reads zero
            rdata_next = {ra7_io & osc_in_pin_in, ra6_io & osc_out_pin_in, 6'h00};
        end else if (hit(addr_in, icc_pkg::DIR_OFFSET)) begin
            rdata_next = {dir_reg, 6'h00};
        end
    end

    // data stand for one cycle only, zero otherwise
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_reg <= 8'h00;
        end else if (rd_in) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // source enables and path selects
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            fast_en_reg <= 1'b1;
            slow_en_reg <= 1'b1;
            lf_fast_reg <= 1'b0;
            xpll_reg    <= 1'b0;
        end else begin
            // any code from 125 khz up, or the 31k leg taken from fast/256
            fast_en_reg <= (ifs_reg != icc_pkg::IFS_31KHZ) || lfsrc_reg;
            slow_en_reg <= ((ifs_reg == icc_pkg::IFS_31KHZ) && !lfsrc_reg &&
                            (int_mode || scs_reg[1])) ||
                           pwrup_timer_en_in || fail_safe_en_in ||
                           watchdog_en_in || two_speed_en_in;
            lf_fast_reg <= lfsrc_reg;
            xpll_reg    <= (osc_mode_config_in == icc_pkg::MODE_CRYSTAL_PLL);
        end
    end

    // ------------------------------------------------------------
    // clock out divider, device clock divided by four
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_reg    <= 1'b0;
            clkout_reg <= 1'b0;
        end else if (dev_clk_tick_in) begin
            div_reg <= ~div_reg;
            if (div_reg) begin
                clkout_reg <= ~clkout_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // glitch-free pll switch
    // ------------------------------------------------------------
    // the gate closes for two old-clock ticks, the mux moves while
    // closed, then four ticks pass before it opens; costs a short
    // pause in the device clock but no runt pulse can escape
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sw_state_reg <= icc_pkg::ICC_RUN;
            sw_cnt_reg   <= 3'h0;
            pll_sel_reg  <= 1'b0;
            gate_reg     <= 1'b1;
        end else begin
            unique case (sw_state_reg)
                icc_pkg::ICC_RUN: begin
                    // a new request starts the drain
                    if (pll_want != pll_sel_reg) begin
                        sw_state_reg <= icc_pkg::ICC_GATE_OFF;
                        gate_reg     <= 1'b0;
                        sw_cnt_reg   <= 3'h0;
                    end
                end
                icc_pkg::ICC_GATE_OFF: begin
                    if (sw_cnt_reg == icc_pkg::OLD_CLK_TICKS) begin
                        pll_sel_reg  <= pll_want;
                        sw_state_reg <= icc_pkg::ICC_SWITCH;
                        sw_cnt_reg   <= 3'h0;
                    end else if (dev_clk_tick_in) begin
                        sw_cnt_reg <= sw_cnt_reg + 3'h1;
                    end
                end
                icc_pkg::ICC_SWITCH: begin
                    if (sw_cnt_reg == icc_pkg::NEW_CLK_TICKS) begin
                        gate_reg     <= 1'b1;
                        sw_state_reg <= icc_pkg::ICC_RUN;
                        sw_cnt_reg   <= 3'h0;
                    end else if (dev_clk_tick_in) begin
                        sw_cnt_reg <= sw_cnt_reg + 3'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // oscillator pin drive
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            out_pin_reg  <= 1'b0;
            out_oe_n_reg <= 1'b1;
            in_pin_reg   <= 1'b0;
            in_oe_n_reg  <= 1'b1;
        end else begin
            if (clkout_on) begin
                out_pin_reg  <= clkout_reg;
                out_oe_n_reg <= 1'b0;
            end else if (ra6_io) begin
                out_pin_reg  <= port_reg[6];
                out_oe_n_reg <= dir_reg[6];
            end else begin
                // pin belongs to the oscillator circuit
                out_pin_reg  <= 1'b0;
                out_oe_n_reg <= 1'b1;
            end
            if (ra7_io) begin
                in_pin_reg  <= port_reg[7];
                in_oe_n_reg <= dir_reg[7];
            end else begin
                in_pin_reg  <= 1'b0;
                in_oe_n_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_out            = rdata_reg;
    assign fast_src_en_out      = fast_en_reg;
    assign slow_src_en_out      = slow_en_reg;
    assign fast_trim_out        = tune_reg;
    assign post_sel_out         = ifs_reg;
    assign lf_from_fast_out     = lf_fast_reg;
    assign pll_sel_out          = pll_sel_reg;
    assign crystal_pll_out      = xpll_reg;
    assign clk_gate_out         = gate_reg;
    assign osc_out_pin_out      = out_pin_reg;
    assign osc_out_pin_oe_n_out = out_oe_n_reg;
    assign osc_in_pin_out       = in_pin_reg;
    assign osc_in_pin_oe_n_out  = in_oe_n_reg;
endmodule
`default_nettype wire

// ---- logic/icc_pkg.sv ----
package icc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] TUNING_OFFSET   = 8'h00;  // internal_osc_tuning
    localparam logic [7:0] CONTROL_OFFSET  = 8'h04;  // osc_control
    localparam logic [7:0] PORT_OFFSET     = 8'h08;  // port_a_register, bits 7:6
    localparam logic [7:0] DIR_OFFSET      = 8'h0c;  // port a direction, 1 = input
    // ------------------------------------------------------------
    // tuning register fields
    // ------------------------------------------------------------
    localparam int LFSRC_BIT      = 7;               // low_freq_source_select
    localparam int PLL_ENABLE_BIT_BIT      = 6;               // pll_enable_bit
    localparam int TUNE_MSB       = 4;               // tune_value 4:0
    localparam logic [4:0] TUNE_RESET = 5'h00;       // calibrated centre
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int IFS_LSB        = 4;               // int_freq_select 6:4
    localparam int SCS_MSB        = 1;               // source select 1:0
    localparam logic [2:0] IFS_RESET  = 3'h4;        // 1 mhz
    localparam logic [2:0] IFS_8MHZ   = 3'h7;
    localparam logic [2:0] IFS_4MHZ   = 3'h6;
    localparam logic [2:0] IFS_31KHZ  = 3'h0;
    localparam logic [1:0] SCS_INTERNAL = 2'h2;      // scs 1x picks internal block
    // ------------------------------------------------------------
    // oscillator mode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_CRYSTAL_PLL  = 4'h6;
    localparam logic [3:0] MODE_INT_CLKOUT   = 4'h9;
    localparam logic [3:0] MODE_INT_DUAL_IO  = 4'h8;
    localparam logic [3:0] MODE_RES_CAP      = 4'h3;
    localparam logic [3:0] MODE_RES_CAP_IO   = 4'h4;
    // ------------------------------------------------------------
    // clock path switching, counted in device clock ticks
    // ------------------------------------------------------------
    localparam logic [2:0] OLD_CLK_TICKS  = 3'h2;    // drain old path
    localparam logic [2:0] NEW_CLK_TICKS  = 3'h4;    // settle new path
    localparam int PLL_FACTOR     = 4;
    localparam int CLKOUT_DIV     = 4;
    localparam int LF_DIVIDE      = 256;
    typedef enum logic [1:0] {ICC_RUN, ICC_GATE_OFF, ICC_SWITCH} icc_sw_state_t;
endpackage

// ---- tb/icc_clock_ctrl_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker for the clock control block
// ----------------------------------------
module icc_clock_ctrl_assertions (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic [3:0] osc_mode_config_in,
    input wire logic       watchdog_en_in,
    input wire logic       fast_src_en_out,
    input wire logic       slow_src_en_out,
    input wire logic [4:0] fast_trim_out,
    input wire logic [2:0] post_sel_out,
    input wire logic       pll_sel_out,
    input wire logic       crystal_pll_out,
    input wire logic       clk_gate_out,
    input wire logic       osc_out_pin_oe_n_out
);
    // one clock domain, so one default for all
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    chk_trim_direct: assert property ((wr_in && addr_in == icc_pkg::TUNING_OFFSET)
        |=> fast_trim_out == $past(wdata_in[4:0])) else $error("trim does not follow tuning write");
    chk_pll_enable_bit_zero: assert property ((rd_in && addr_in == icc_pkg::TUNING_OFFSET && !osc_mode_config_in[3])
        |=> rdata_out[6] == 1'b0) else $error("pll enable reads set outside internal modes");
    chk_bit5_zero: assert property ((rd_in && addr_in == icc_pkg::TUNING_OFFSET)
        |=> rdata_out[5] == 1'b0) else $error("tuning bit five reads set");
    chk_crystal_flag: assert property (1'b1
        |=> crystal_pll_out == ($past(osc_mode_config_in) == icc_pkg::MODE_CRYSTAL_PLL))
        else $error("crystal pll flag wrong");
    chk_slow_watchdog: assert property (watchdog_en_in |=> slow_src_en_out)
        else $error("slow source off with watchdog on");
    chk_fast_at_8mhz: assert property ((post_sel_out == icc_pkg::IFS_8MHZ && $stable(post_sel_out))
        |-> fast_src_en_out) else $error("fast source off at 8 mhz");
    chk_mux_steady: assert property ((clk_gate_out && $past(clk_gate_out)) |-> $stable(pll_sel_out))
        else $error("pll select moved with gate open");
    chk_gate_drop: assert property ((osc_mode_config_in == icc_pkg::MODE_CRYSTAL_PLL && !pll_sel_out
        && clk_gate_out && $past(clk_gate_out)) |=> !clk_gate_out) else $error("gate kept open on pll switch");
    chk_gate_returns: assert property ($fell(clk_gate_out) |-> ##[1:60] clk_gate_out)
        else $error("gate closed too long");
    chk_pll_allowed: assert property ($rose(pll_sel_out) |-> (osc_mode_config_in == icc_pkg::MODE_CRYSTAL_PLL
        || (osc_mode_config_in[3:1] == 3'h4 && post_sel_out[2:1] == 2'h3))) else $error("pll in illegal setting");
    chk_rc_clkout: assert property ((osc_mode_config_in == icc_pkg::MODE_RES_CAP) |=> !osc_out_pin_oe_n_out)
        else $error("out pin not driven in res-cap mode");
endmodule
bind icc_clock_ctrl icc_clock_ctrl_assertions icc_clock_ctrl_assertions_i (.*);
`default_nettype wire

// ---- tb/icc_clock_ctrl_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module icc_clock_ctrl_tb_top;
    logic       sys_clk_in, rst_in, wr_in, rd_in;
    logic       dev_clk_tick_in = 1'b0;      // driven by the tick process only
    logic       pwrup_timer_en_in, fail_safe_en_in, watchdog_en_in, two_speed_en_in;
    logic       osc_out_pin_in, osc_in_pin_in, osc_out_pin_out, osc_in_pin_out;
    logic       osc_out_pin_oe_n_out, osc_in_pin_oe_n_out, fast_src_en_out, slow_src_en_out;
    logic       lf_from_fast_out, pll_sel_out, crystal_pll_out, clk_gate_out;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [3:0] osc_mode_config_in;
    logic [4:0] fast_trim_out;
    logic [2:0] post_sel_out;
    int         fail_count, comparisons;
    icc_clock_ctrl icc_clock_ctrl_i (.*);
    // 100 ns clock
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    // device clock tick every second cycle, so switch counts take real time
    always @(posedge sys_clk_in) begin
        dev_clk_tick_in <= ~dev_clk_tick_in;
    end
    task automatic test_done();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    // line up on an edge, one strobe cycle, then one idle cycle so strobes never collide
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 check("read data", exp, rdata_out);
        @(posedge sys_clk_in);
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    // 16 cycles of a divide-by-four out pin give exactly four changes
    task automatic count_toggles();
        int   n;
        logic prev;
        n = 0;
        for (int i = 0; i < 16; i++) begin
            prev = osc_out_pin_out;
            @(posedge sys_clk_in);
            #1 if (osc_out_pin_out !== prev) n++;
        end
        check("out pin changes", 8'h04, 8'(n));
    endtask
    // bounded wait for the pll mux to land with the gate open again
    task automatic wait_pll(input logic exp);
        int n;
        n = 0;
        while (n < 80 && !(pll_sel_out === exp && clk_gate_out === 1'b1)) begin
            @(posedge sys_clk_in);
            n++;
        end
        #1 check("pll select", 8'(exp), 8'(pll_sel_out));
        if (n == 80) begin
            fail_count++;
            test_done();
        end
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        $display("wrong value run length expected end seen timeout");
        fail_count++;
        test_done();
    end
    initial begin
        {rst_in, wr_in, rd_in, addr_in, wdata_in} = '0;
        {pwrup_timer_en_in, fail_safe_en_in, watchdog_en_in, two_speed_en_in} = 4'h0;
        {osc_out_pin_in, osc_in_pin_in, fail_count, comparisons} = '0;
        osc_mode_config_in = icc_pkg::MODE_RES_CAP;
        rst_in = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(posedge sys_clk_in);
        // reset values, unmapped read, reserved and forced bits
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h00);
        reg_rd(icc_pkg::CONTROL_OFFSET, 8'h40);
        check("post select", 8'h04, 8'(post_sel_out));
        reg_rd(8'h10, 8'h00);
        reg_wr(icc_pkg::TUNING_OFFSET, 8'hff);
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h9f);
        settle();
        check("trim", 8'h1f, 8'(fast_trim_out));
        check("lf from fast", 8'h01, 8'(lf_from_fast_out));
        count_toggles();
        // port pins in the i/o modes
        @(posedge sys_clk_in);
        osc_mode_config_in <= icc_pkg::MODE_RES_CAP_IO;
        reg_wr(icc_pkg::DIR_OFFSET, 8'h00);
        reg_wr(icc_pkg::PORT_OFFSET, 8'h40);
        settle();
        check("io pins", 8'h05, 8'({osc_out_pin_out, osc_out_pin_oe_n_out, osc_in_pin_oe_n_out}));
        @(posedge sys_clk_in);
        osc_mode_config_in <= icc_pkg::MODE_INT_DUAL_IO;
        reg_wr(icc_pkg::PORT_OFFSET, 8'h80);
        settle();
        check("dual pins", 8'h08,
              8'({osc_in_pin_out, osc_in_pin_oe_n_out, osc_out_pin_out, osc_out_pin_oe_n_out}));
        reg_wr(icc_pkg::DIR_OFFSET, 8'hc0);
        {osc_in_pin_in, osc_out_pin_in} <= 2'h3;
        settle();
        reg_rd(icc_pkg::PORT_OFFSET, 8'hc0);
        osc_mode_config_in <= icc_pkg::MODE_INT_CLKOUT;
        settle();
        count_toggles();
        check("in pin oe", 8'h01, 8'(osc_in_pin_oe_n_out));
        // internal pll needs mode, enable bit and 8 or 4 mhz
        reg_wr(icc_pkg::CONTROL_OFFSET, 8'h70);
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h40);
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h40);
        reg_rd(icc_pkg::CONTROL_OFFSET, 8'h74);
        wait_pll(1'b1);
        reg_wr(icc_pkg::CONTROL_OFFSET, 8'h50);
        // the gate has closed by the edge after the write lands
        #1 check("clock gate", 8'h00, 8'(clk_gate_out));
        wait_pll(1'b0);
        reg_wr(icc_pkg::CONTROL_OFFSET, 8'h60);
        wait_pll(1'b1);
        @(posedge sys_clk_in);
        osc_mode_config_in <= icc_pkg::MODE_RES_CAP;
        wait_pll(1'b0);
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h00);
        // crystal pll follows the mode alone
        osc_mode_config_in <= icc_pkg::MODE_CRYSTAL_PLL;
        wait_pll(1'b1);
        check("crystal pll", 8'h01, 8'(crystal_pll_out));
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h40);
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h00);
        osc_mode_config_in <= icc_pkg::MODE_INT_DUAL_IO;
        wait_pll(1'b0);
        // low-frequency sources and feature enables
        reg_wr(icc_pkg::CONTROL_OFFSET, 8'h00);
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h00);
        settle();
        check("slow fast", 8'h02, 8'({slow_src_en_out, fast_src_en_out}));
        // software steps the trim one code down, as after framing errors
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h0f);
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h0e);
        reg_rd(icc_pkg::TUNING_OFFSET, 8'h0e);
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h90);
        settle();
        check("fast slow lf trim", 8'hb0,
              {fast_src_en_out, slow_src_en_out, lf_from_fast_out, fast_trim_out});
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_in);
            {pwrup_timer_en_in, fail_safe_en_in, watchdog_en_in, two_speed_en_in} <= 4'h1 << i;
            settle();
            check("slow with feature", 8'h01, 8'(slow_src_en_out));
        end
        // with all four feature enables off, outside the internal modes the slow source runs only when picked by source select
        @(posedge sys_clk_in);
        {pwrup_timer_en_in, fail_safe_en_in, watchdog_en_in, two_speed_en_in} <= 4'h0;
        osc_mode_config_in <= icc_pkg::MODE_RES_CAP;
        reg_wr(icc_pkg::TUNING_OFFSET, 8'h00);
        settle();
        check("slow unselected", 8'h00, 8'(slow_src_en_out));
        reg_wr(icc_pkg::CONTROL_OFFSET, 8'h02);
        settle();
        check("slow selected", 8'h01, 8'(slow_src_en_out));
        test_done();
    end
endmodule
`default_nettype wire
